// ===== bench/spmflr_sva.sv
/*
 * Checker for the link between the CPU-core end and the controller.
 * Assumes it is instantiated beside the interface, on the one hclk domain.
 */
`timescale 1ns/1ns
module spmflr_sva (
   input wire logic                             hclk,
   input wire logic                             hresetn,
   input wire logic                             ctl_wr,
   input wire logic [7:0]                       ctl_wdata,
   input wire logic [7:0]                       ctl_rdata,
   input wire logic                             lpm_req,
   input wire logic [spmflr_pkg::SPMFLR_ZW-1:0] lpm_addr,
   input wire logic                             lpm_valid,
   input wire logic [7:0]                       lpm_data,
   input wire logic                             spm_req,
   input wire logic                             ee_busy
);
   import spmflr_pkg::*;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ee_busy is a registered copy, so it shows the busy level of a load one cycle after that load
   wire arm_rd = ctl_wr && ctl_wdata[4:0] == 5'h09;
   wire arm_re = ctl_wr && ctl_wdata[4:0] == 5'h11 && !ee_busy;
   ////////////////////////////////////////////////////////////
   property p_lpm_lat; lpm_req |-> ##2 lpm_valid; endproperty
   a_lpm_lat: assert property (p_lpm_lat) else $error("load answer not two cycles later");
   property p_valid_cause; lpm_valid |-> $past(lpm_req, 2); endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("load answer without request");
   // flash op may outlive a system reset, so only the timed bits are tied down
   property p_ctl_rst; $rose(hresetn) |-> !ctl_rdata[SPMFLR_LS] && !ctl_rdata[SPMFLR_RE] && !lpm_valid; endproperty
   a_ctl_rst: assert property (p_ctl_rst) else $error("control bits set after reset");
   property p_bit5; ctl_rdata[5] == 1'b0; endproperty
   a_bit5: assert property (p_bit5) else $error("unused control bit reads one");
   property p_lock_top;
      arm_rd ##[1:3] (lpm_req && lpm_addr == 17'h00001) ##1 !ee_busy |-> ##1 lpm_valid && lpm_data[7:6] == 2'h3;
   endproperty
   a_lock_top: assert property (p_lock_top) else $error("lock byte top bits wrong");
   property p_rb_clr;
      arm_rd ##[1:3] lpm_req ##1 !ee_busy |-> ##[0:2] !ctl_rdata[SPMFLR_LS] && !ctl_rdata[SPMFLR_SE];
   endproperty
   a_rb_clr: assert property (p_rb_clr) else $error("bits not cleared after readback");
   property p_timeout;
      arm_rd ##1 lpm_req ##1 ee_busy |-> ctl_rdata[SPMFLR_LS] ##[2:4] !ctl_rdata[SPMFLR_LS];
   endproperty
   a_timeout: assert property (p_timeout) else $error("blocked readback bits not timed out");
   property p_rww; arm_re ##[1:4] spm_req |-> ##[1:3] !ctl_rdata[SPMFLR_SB]; endproperty
   a_rww: assert property (p_rww) else $error("section busy not cleared");
endmodule

// ===== bench/tb_spm_fuse_lock_readback.sv
/*
 * Self-checking bench: both ends joined by the interface, driven over AHB-Lite.
 * Assumes a combinational flash model and a fast RC tick to keep runs short.
 */
`timescale 1ns/1ns
module tb_spm_fuse_lock_readback;
   import spmflr_pkg::*;
   localparam int  PT = 5;
   logic           hclk = 1'b0, hresetn = 1'b0, por_resetn = 1'b0, ee_write_busy = 1'b0;
   logic           rc_tick = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]     htrans = 2'h0;
   logic [2:0]     hsize = 3'h2, rc_cnt = 3'h0;
   logic [31:0]    haddr = 32'h0, hwdata = 32'h0;
   logic [5:0]     lock_prog = 6'h2D;
   logic [7:0]     fuse_low_prog = 8'hA1, fuse_high_prog = 8'h3C, fuse_ext_prog = 8'h0F;
   wire logic [7:0]  fl_rdata;
   wire logic [16:0] fl_rd_addr, fl_addr;
   wire logic [15:0] fl_wdata;
   spmflr_fl_cmd_t   fl_cmd;
   wire logic        fl_busy, hreadyout, ints_blocked;
   wire logic [1:0]  hresp;
   wire logic [31:0] hrdata;
   int             failures = 0, checked = 0, prog_cmds = 0, busy_ticks = 0;
   spmflr_if link ();
   spmflr_dev #(.PROG_TICKS(PT)) i_spmflr_dev (.cpu(link), .hclk(hclk), .hresetn(hresetn),
      .por_resetn(por_resetn), .ee_write_busy(ee_write_busy), .rc_tick(rc_tick), .lock_prog(lock_prog),
      .fuse_low_prog(fuse_low_prog), .fuse_high_prog(fuse_high_prog), .fuse_ext_prog(fuse_ext_prog),
      .fl_rdata(fl_rdata), .fl_rd_addr(fl_rd_addr), .fl_cmd(fl_cmd), .fl_addr(fl_addr),
      .fl_wdata(fl_wdata), .fl_busy(fl_busy));
   spmflr_host i_spmflr_host (.cpu(link), .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ints_blocked(ints_blocked));
   spmflr_sva i_spmflr_sva (.hclk(hclk), .hresetn(hresetn), .ctl_wr(link.ctl_wr), .ctl_wdata(link.ctl_wdata),
      .ctl_rdata(link.ctl_rdata), .lpm_req(link.lpm_req), .lpm_addr(link.lpm_addr),
      .lpm_valid(link.lpm_valid), .lpm_data(link.lpm_data), .spm_req(link.spm_req), .ee_busy(link.ee_busy));
   // flash byte is a simple function of its address so reads are predictable
   assign fl_rdata = fl_rd_addr[7:0] ^ 8'h5A;
   always #2 hclk = ~hclk;
   always @(posedge hclk) begin
      rc_cnt <= rc_cnt + 3'h1;
      rc_tick <= (rc_cnt == 3'h7);
      if (fl_cmd inside {SPMFLR_FL_ERASE, SPMFLR_FL_WRITE, SPMFLR_FL_LOCK}) prog_cmds <= prog_cmds + 1;
      // ticks seen while busy, counted at the controller's own sampling edge
      if (fl_busy && rc_tick) busy_ticks <= busy_ticks + 1;
   end
   ////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   // ee_mid raises the eeprom write only once the host has passed its busy poll
   task run(input spmflr_op_t op, input logic [16:0] z, input logic ee_mid, output logic [31:0] r);
      int n;
      if (ee_mid) fork begin @(posedge hclk iff ints_blocked === 1'b1); ee_write_busy <= 1'b1; end join_none
      ahb(1'b1, {28'h0, SPMFLR_H_ZPTR}, {15'h0, z}, r);
      ahb(1'b1, {28'h0, SPMFLR_H_CMD}, {29'h0, op}, r);
      n = 0;
      do begin ahb(1'b0, {28'h0, SPMFLR_H_STAT}, 32'h0, r); n++; end while (r[0] !== 1'b0 && n < 400);
      ee_write_busy <= 1'b0;
      chk("ints blocked", 0, ints_blocked);
   endtask
   ////////////////////////////////////////////////////////////
   task t_fuse;
      logic [31:0] r;
      logic [7:0] e [4];
      e = '{~fuse_low_prog, {2'h3, ~lock_prog}, ~fuse_ext_prog, ~fuse_high_prog};
      for (int z = 0; z < 4; z++) begin
         run(SPMFLR_OP_RDFUSE, 17'(z), 1'b0, r);
         chk("readback byte", {24'h0, e[z]}, {24'h0, r[15:8]});
      end
   endtask
   task t_plain;
      logic [31:0] r;
      run(SPMFLR_OP_RDFL, 17'h00123, 1'b0, r);
      chk("flash byte", 32'h79, {24'h0, r[15:8]});
      ahb(1'b0, 32'h00000020, 32'h0, r);
      chk("hresp", 0, {30'h0, hresp});
   endtask
   task t_load;
      logic [31:0] r;
      ahb(1'b1, {28'h0, SPMFLR_H_WDATA}, 32'h0000BEEF, r);
      run(SPMFLR_OP_LOAD, 17'h00100, 1'b0, r);
      chk("flash word", 32'h0000BEEF, {16'h0, fl_wdata});
      chk("flash word address", 32'h00000100, {15'h0, fl_addr});
      ahb(1'b0, {28'h0, SPMFLR_H_ZPTR}, 32'h0, r);
      chk("next pointer", 32'h00000102, r);
   endtask
   task t_ee;
      logic [31:0] r;
      int n;
      n = prog_cmds;
      run(SPMFLR_OP_RDFUSE, 17'h00001, 1'b1, r);
      chk("blocked readback", 32'h5B, {24'h0, r[15:8]});
      run(SPMFLR_OP_ERASE, 17'h00100, 1'b1, r);
      repeat (4) @(posedge hclk);
      chk("program commands", n, prog_cmds);
   endtask
   task t_erase;
      logic [31:0] r;
      int tk;
      int n;
      tk = busy_ticks;
      run(SPMFLR_OP_ERASE, 17'h00100, 1'b0, r);
      n = 0;
      while (fl_busy === 1'b1 && n < 2000) begin @(posedge hclk); n++; end
      chk("rc ticks", PT, busy_ticks - tk);
      chk("section busy", 1, link.ctl_rdata[SPMFLR_SB]);
      run(SPMFLR_OP_RWWEN, 17'h0, 1'b0, r);
      chk("section busy", 0, link.ctl_rdata[SPMFLR_SB]);
   endtask
   task t_reset;
      logic [31:0] r;
      int n;
      run(SPMFLR_OP_WRITE, 17'h00100, 1'b0, r);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("busy over reset", 1, fl_busy);
      n = 0;
      while (fl_busy === 1'b1 && n < 2000) begin @(posedge hclk); n++; end
      chk("write finished", 0, fl_busy);
   endtask
   task report_and_stop;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      por_resetn <= 1'b1;
      @(posedge hclk);
      t_fuse;
      t_plain;
      t_load;
      t_ee;
      t_erase;
      t_reset;
      report_and_stop;
   end
   initial begin
      #200000;
      failures++;
      report_and_stop;
   end
endmodule

// ===== include/spmflr_if.sv
/*
 * Link between the CPU core end and the self-programming controller.
 * Assumes both ends run on the same hclk; all signals are single-driver.
 */
`timescale 1ns/1ns
interface spmflr_if;
   import spmflr_pkg::*;
   logic                 ctl_wr;
   logic [7:0]           ctl_wdata;
   logic [7:0]           ctl_rdata;
   logic                 lpm_req;
   logic [SPMFLR_ZW-1:0] lpm_addr;
   logic                 lpm_valid;
   logic [7:0]           lpm_data;
   logic                 spm_req;
   logic [SPMFLR_ZW-1:0] spm_addr;
   logic [15:0]          spm_data;
   logic                 ee_busy;

   modport dev (
      input  ctl_wr, ctl_wdata, lpm_req, lpm_addr, spm_req, spm_addr, spm_data,
      output ctl_rdata, lpm_valid, lpm_data, ee_busy
   );
   modport host (
      output ctl_wr, ctl_wdata, lpm_req, lpm_addr, spm_req, spm_addr, spm_data,
      input  ctl_rdata, lpm_valid, lpm_data, ee_busy
   );
endinterface

// ===== include/spmflr_pkg.sv
/*
 * Constants and types shared by both ends of the self-programming link.
 * Assumes a single 250 MHz CPU clock and a calibrated RC tick pulse.
 */
package spmflr_pkg;
   localparam int unsigned SPMFLR_ZW       = 17;
   // control register location and layout
   localparam logic [7:0]  SPMFLR_CTL_OFS  = 8'h68;
   localparam logic [7:0]  SPMFLR_CTL_RST  = 8'h00;
   localparam int unsigned SPMFLR_SE       = 0;
   localparam int unsigned SPMFLR_PE       = 1;
   localparam int unsigned SPMFLR_PW       = 2;
   localparam int unsigned SPMFLR_LS       = 3;
   localparam int unsigned SPMFLR_RE       = 4;
   localparam int unsigned SPMFLR_SB       = 6;
   localparam int unsigned SPMFLR_IE       = 7;
   localparam logic [7:0]  SPMFLR_CTL_WMSK = 8'h9F;
   // pointer values selecting the readback byte
   localparam logic [1:0]  SPMFLR_Z_FLOW   = 2'h0;
   localparam logic [1:0]  SPMFLR_Z_LOCK   = 2'h1;
   localparam logic [1:0]  SPMFLR_Z_FEXT   = 2'h2;
   localparam logic [1:0]  SPMFLR_Z_FHIGH  = 2'h3;
   // timed-sequence windows in CPU cycles
   localparam logic [2:0]  SPMFLR_LPM_WIN  = 3'h3;
   localparam logic [2:0]  SPMFLR_SPM_WIN  = 3'h4;
   // flash operation time, counted in RC ticks
   localparam int          SPMFLR_CLK_NS   = 4;
   localparam int          SPMFLR_TMIN_NS  = 3700000;
   localparam int          SPMFLR_TMAX_NS  = 4500000;
   localparam int          SPMFLR_RC_NS    = 1000;
   localparam int          SPMFLR_PROG_TICKS = (SPMFLR_TMIN_NS + SPMFLR_RC_NS - 1) / SPMFLR_RC_NS;
   localparam logic [15:0] SPMFLR_NO_READ_WHILE_WRITE_REGION_WORD = 16'hF000;
   // host register map
   localparam logic [3:0]  SPMFLR_H_CMD    = 4'h0;
   localparam logic [3:0]  SPMFLR_H_ZPTR   = 4'h4;
   localparam logic [3:0]  SPMFLR_H_WDATA  = 4'h8;
   localparam logic [3:0]  SPMFLR_H_STAT   = 4'hC;
   localparam logic [1:0]  SPMFLR_HRESP_OK = 2'h0;

   typedef enum logic [2:0] {
      SPMFLR_FL_NONE  = 3'h0,
      SPMFLR_FL_LOAD  = 3'h1,
      SPMFLR_FL_ERASE = 3'h2,
      SPMFLR_FL_WRITE = 3'h3,
      SPMFLR_FL_LOCK  = 3'h4,
      SPMFLR_FL_REEN  = 3'h5
   } spmflr_fl_cmd_t;

   typedef enum logic [2:0] {
      SPMFLR_OP_LOAD   = 3'h0,
      SPMFLR_OP_ERASE  = 3'h1,
      SPMFLR_OP_WRITE  = 3'h2,
      SPMFLR_OP_LOCKWR = 3'h3,
      SPMFLR_OP_RDFUSE = 3'h4,
      SPMFLR_OP_RWWEN  = 3'h5,
      SPMFLR_OP_RDFL   = 3'h6
   } spmflr_op_t;

   typedef enum logic [2:0] {
      SPMFLR_ST_IDLE   = 3'b000,
      SPMFLR_ST_WSE    = 3'b001,
      SPMFLR_ST_WEE    = 3'b011,
      SPMFLR_ST_WRCTL  = 3'b010,
      SPMFLR_ST_ISSUE  = 3'b110,
      SPMFLR_ST_WRD    = 3'b111,
      SPMFLR_ST_CHECK  = 3'b101,
      SPMFLR_ST_FINISH = 3'b100
   } spmflr_state_t;
endpackage

// ===== logic/spmflr_dev.sv
/*
 * Self-programming controller: control register, timed windows,
 * fuse/lock readback, flash operation timing and section busy flag.
 * Assumes the flash array answers fl_rdata combinationally from fl_rd_addr,
 * and rc_tick is a one-cycle pulse from the calibrated RC oscillator.
 */
`timescale 1ns/1ns

module spmflr_dev #(
   parameter int PROG_TICKS = spmflr_pkg::SPMFLR_PROG_TICKS
) (
   spmflr_if.dev                            cpu,
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        por_resetn,
   input  wire logic                        ee_write_busy,
   input  wire logic                        rc_tick,
   input  wire logic [5:0]                  lock_prog,
   input  wire logic [7:0]                  fuse_low_prog,
   input  wire logic [7:0]                  fuse_high_prog,
   input  wire logic [7:0]                  fuse_ext_prog,
   input  wire logic [7:0]                  fl_rdata,
   output logic [spmflr_pkg::SPMFLR_ZW-1:0] fl_rd_addr,
   output spmflr_pkg::spmflr_fl_cmd_t       fl_cmd,
   output logic [spmflr_pkg::SPMFLR_ZW-1:0] fl_addr,
   output logic [15:0]                      fl_wdata,
   output logic                             fl_busy
);
   import spmflr_pkg::*;

   localparam int TW = $clog2(PROG_TICKS + 1);

   logic [7:0]           ctl_ff;
   logic                 sect_busy_ff;
   logic [2:0]           win_ff;
   logic                 prog_busy_ff;
   logic [TW-1:0]        tick_cnt_ff;
   logic                 rb_sel_ff;
   logic [7:0]           rb_byte_ff;
   logic                 rd_pend_ff;
   logic                 lpm_valid_ff;
   logic [7:0]           lpm_data_ff;
   logic [7:0]           ctl_rdata_ff;
   logic                 ee_busy_ff;
   logic [SPMFLR_ZW-1:0] fl_rd_addr_ff;
   spmflr_fl_cmd_t       fl_cmd_ff;
   logic [SPMFLR_ZW-1:0] fl_addr_ff;
   logic [15:0]          fl_wdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // readback byte selection

   function automatic logic [7:0] rb_byte(input logic [1:0] z);
      logic [7:0] b;
      b = 8'hFF;
      case (z)
         SPMFLR_Z_LOCK:  b = {2'b11, ~lock_prog};
         SPMFLR_Z_FLOW:  b = ~fuse_low_prog;
         SPMFLR_Z_FHIGH: b = ~fuse_high_prog;
         SPMFLR_Z_FEXT:  b = ~fuse_ext_prog;
         default:        b = 8'hFF;
      endcase
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode

   wire win_open   = (win_ff != 3'h0);
   wire lpm_in_win = win_open & (win_ff <= SPMFLR_LPM_WIN);
   wire win_last   = (win_ff == SPMFLR_SPM_WIN);
   wire op_long    = ctl_ff[SPMFLR_PE] | ctl_ff[SPMFLR_PW];
   wire rb_armed   = ctl_ff[SPMFLR_SE] & ctl_ff[SPMFLR_LS] & ~op_long & ~ctl_ff[SPMFLR_RE];
   wire rb_hit     = cpu.lpm_req & lpm_in_win & rb_armed & ~ee_write_busy;
   wire spm_ok     = cpu.spm_req & win_open & ctl_ff[SPMFLR_SE] & ~ee_write_busy & ~prog_busy_ff;
   wire start_prog = spm_ok & (op_long | ctl_ff[SPMFLR_LS]);
   wire quick_done = spm_ok & ~start_prog;
   wire prog_done  = prog_busy_ff & rc_tick & (tick_cnt_ff == TW'(PROG_TICKS - 1));
   wire win_expire = win_last & ~spm_ok & ~cpu.ctl_wr;
   wire clr_cmd    = win_expire | rb_hit | quick_done | prog_done;
   wire ctl_wr_ok  = cpu.ctl_wr & ~prog_busy_ff;
   wire in_rww     = (cpu.spm_addr[SPMFLR_ZW-1:1] < SPMFLR_NO_READ_WHILE_WRITE_REGION_WORD);
   wire sb_set     = start_prog & op_long & in_rww;
   wire sb_clr     = quick_done;

   spmflr_fl_cmd_t op_sel;
   assign op_sel = ~spm_ok                    ? SPMFLR_FL_NONE  :
                   ctl_ff[SPMFLR_PE]          ? SPMFLR_FL_ERASE :
                   ctl_ff[SPMFLR_PW]          ? SPMFLR_FL_WRITE :
                   ctl_ff[SPMFLR_LS]          ? SPMFLR_FL_LOCK  :
                   ctl_ff[SPMFLR_RE]          ? SPMFLR_FL_REEN  : SPMFLR_FL_LOAD;

   wire [7:0] ctl_view = {ctl_ff[SPMFLR_IE], sect_busy_ff, 1'b0, ctl_ff[4:1], ctl_ff[SPMFLR_SE] | prog_busy_ff};

   ////////////////////////////////////////////////////////////////////////
   // control register and window

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_ff <= SPMFLR_CTL_RST;
      end else if (ctl_wr_ok) begin
         ctl_ff <= cpu.ctl_wdata & SPMFLR_CTL_WMSK;
      end else if (cpu.ctl_wr) begin
         ctl_ff[SPMFLR_IE] <= cpu.ctl_wdata[SPMFLR_IE];
      end else if (clr_cmd) begin
         ctl_ff[4:0] <= 5'h00;
      end
   end

   // window counts cycles since store enable was written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_ff <= 3'h0;
      end else if (ctl_wr_ok) begin
         win_ff <= cpu.ctl_wdata[SPMFLR_SE] ? 3'h1 : 3'h0;
      end else if (spm_ok | rb_hit | win_last) begin
         win_ff <= 3'h0;
      end else if (win_open) begin
         win_ff <= win_ff + 3'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sect_busy_ff <= 1'b0;
      end else if (sb_set) begin
         sect_busy_ff <= 1'b1;
      end else if (sb_clr) begin
         sect_busy_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flash operation timer
   // runs on power-on reset only: a system reset must not cut a write short

   always_ff @(posedge hclk or negedge por_resetn) begin
      if (!por_resetn) begin
         prog_busy_ff <= 1'b0;
         tick_cnt_ff  <= '0;
      end else if (start_prog) begin
         prog_busy_ff <= 1'b1;
         tick_cnt_ff  <= '0;
      end else if (prog_done) begin
         prog_busy_ff <= 1'b0;
      end else if (prog_busy_ff & rc_tick) begin
         tick_cnt_ff  <= tick_cnt_ff + TW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // load path: two-cycle answer

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rb_sel_ff     <= 1'b0;
         rb_byte_ff    <= 8'h00;
         rd_pend_ff    <= 1'b0;
         fl_rd_addr_ff <= '0;
      end else begin
         rd_pend_ff <= cpu.lpm_req;
         if (cpu.lpm_req) begin
            rb_sel_ff     <= rb_hit;
            rb_byte_ff    <= rb_byte(cpu.lpm_addr[1:0]);
            fl_rd_addr_ff <= cpu.lpm_addr;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lpm_valid_ff <= 1'b0;
         lpm_data_ff  <= 8'h00;
      end else begin
         lpm_valid_ff <= rd_pend_ff;
         if (rd_pend_ff) begin
            lpm_data_ff <= rb_sel_ff ? rb_byte_ff : fl_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flash array strobes and status

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fl_cmd_ff    <= SPMFLR_FL_NONE;
         fl_addr_ff   <= '0;
         fl_wdata_ff  <= 16'h0000;
         ctl_rdata_ff <= SPMFLR_CTL_RST;
         ee_busy_ff   <= 1'b0;
      end else begin
         fl_cmd_ff    <= op_sel;
         ctl_rdata_ff <= ctl_view;
         ee_busy_ff   <= ee_write_busy;
         if (spm_ok) begin
            fl_addr_ff  <= cpu.spm_addr;
            fl_wdata_ff <= cpu.spm_data;
         end
      end
   end

   assign cpu.ctl_rdata = ctl_rdata_ff;
   assign cpu.lpm_valid = lpm_valid_ff;
   assign cpu.lpm_data  = lpm_data_ff;
   assign cpu.ee_busy   = ee_busy_ff;
   assign fl_rd_addr    = fl_rd_addr_ff;
   assign fl_cmd        = fl_cmd_ff;
   assign fl_addr       = fl_addr_ff;
   assign fl_wdata      = fl_wdata_ff;
   assign fl_busy       = prog_busy_ff;
endmodule

// ===== logic/spmflr_host.sv
/*
 * CPU-core end: runs the boot loader timed sequences on request.
 * Software orders it over a zero-wait AHB-Lite slave; one slave on the bus.
 */
`timescale 1ns/1ns
module spmflr_host (
   spmflr_if.host                  cpu,
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic [1:0]              hresp,
   output logic [31:0]             hrdata,
   output logic                    ints_blocked
);
   import spmflr_pkg::*;

   spmflr_state_t        st_ff;
   spmflr_op_t           op_ff;
   logic [SPMFLR_ZW-1:0] z_ff;
   logic [15:0]          wdata_ff;
   logic [7:0]           result_ff;
   logic                 ap_wr_ff;
   logic [3:0]           ap_addr_ff;
   logic [31:0]          hrdata_ff;
   logic                 ints_ff;
   logic                 ctl_wr_ff;
   logic [7:0]           ctl_wdata_ff;
   logic                 lpm_req_ff;
   logic                 spm_req_ff;

   // control value for each order
   function automatic logic [7:0] ctl_val(input spmflr_op_t op);
      logic [7:0] v;
      v = 8'h00;
      v[SPMFLR_SE] = 1'b1;
      case (op)
         SPMFLR_OP_ERASE:  v[SPMFLR_PE] = 1'b1;
         SPMFLR_OP_WRITE:  v[SPMFLR_PW] = 1'b1;
         SPMFLR_OP_LOCKWR: v[SPMFLR_LS] = 1'b1;
         SPMFLR_OP_RDFUSE: v[SPMFLR_LS] = 1'b1;
         SPMFLR_OP_RWWEN:  v[SPMFLR_RE] = 1'b1;
         default:          v[SPMFLR_SE] = 1'b1;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire        busy    = (st_ff != SPMFLR_ST_IDLE);
   wire        ap_take = hsel & htrans[1] & hready;
   wire        dp_wr   = ap_wr_ff & ~busy;
   wire        go      = dp_wr & (ap_addr_ff == SPMFLR_H_CMD);
   wire        is_lpm  = (op_ff == SPMFLR_OP_RDFUSE) | (op_ff == SPMFLR_OP_RDFL);
   wire [31:0] stat    = {16'h0000, result_ff, 6'h00, ints_ff, busy};
   wire [31:0] rd_mux  = (haddr[3:0] == SPMFLR_H_ZPTR)  ? {15'h0000, z_ff} :
                         (haddr[3:0] == SPMFLR_H_WDATA) ? {16'h0000, wdata_ff} :
                         (haddr[3:0] == SPMFLR_H_STAT)  ? stat : {29'h0, op_ff};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_ff   <= 1'b0;
         ap_addr_ff <= 4'h0;
         hrdata_ff  <= 32'h0000_0000;
      end else begin
         ap_wr_ff <= ap_take & hwrite;
         if (ap_take) begin
            ap_addr_ff <= haddr[3:0];
         end
         if (ap_take & ~hwrite) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff        <= SPMFLR_ST_IDLE;
         op_ff        <= SPMFLR_OP_LOAD;
         z_ff         <= '0;
         wdata_ff     <= 16'h0000;
         result_ff    <= 8'h00;
         ints_ff      <= 1'b0;
         ctl_wr_ff    <= 1'b0;
         ctl_wdata_ff <= 8'h00;
         lpm_req_ff   <= 1'b0;
         spm_req_ff   <= 1'b0;
      end else begin
         ctl_wr_ff  <= 1'b0;
         lpm_req_ff <= 1'b0;
         spm_req_ff <= 1'b0;
         case (st_ff)
            SPMFLR_ST_IDLE: begin
               if (dp_wr & (ap_addr_ff == SPMFLR_H_ZPTR)) begin
                  z_ff <= hwdata[SPMFLR_ZW-1:0];
               end
               if (dp_wr & (ap_addr_ff == SPMFLR_H_WDATA)) begin
                  wdata_ff <= hwdata[15:0];
               end
               if (go) begin
                  op_ff <= spmflr_op_t'(hwdata[2:0]);
                  st_ff <= SPMFLR_ST_WSE;
               end
            end
            SPMFLR_ST_WSE: begin
               if (!cpu.ctl_rdata[SPMFLR_SE]) begin
                  st_ff <= (op_ff == SPMFLR_OP_RWWEN) ? SPMFLR_ST_CHECK : SPMFLR_ST_WEE;
               end
            end
            SPMFLR_ST_CHECK: begin
               st_ff <= cpu.ctl_rdata[SPMFLR_SB] ? SPMFLR_ST_WEE : SPMFLR_ST_FINISH;
            end
            SPMFLR_ST_WEE: begin
               ints_ff <= 1'b1;
               if (!cpu.ee_busy) begin
                  st_ff <= (op_ff == SPMFLR_OP_RDFL) ? SPMFLR_ST_ISSUE : SPMFLR_ST_WRCTL;
               end
            end
            SPMFLR_ST_WRCTL: begin
               ctl_wr_ff    <= 1'b1;
               ctl_wdata_ff <= ctl_val(op_ff);
               st_ff        <= SPMFLR_ST_ISSUE;
            end
            // load or store on first window cycle; a plain flash read opens no window
            SPMFLR_ST_ISSUE: begin
               lpm_req_ff <= is_lpm;
               spm_req_ff <= ~is_lpm;
               if (is_lpm) begin
                  st_ff <= SPMFLR_ST_WRD;
               end else begin
                  ints_ff <= 1'b0;
                  st_ff   <= (op_ff == SPMFLR_OP_RWWEN) ? SPMFLR_ST_WSE : SPMFLR_ST_FINISH;
               end
            end
            SPMFLR_ST_WRD: begin
               if (cpu.lpm_valid) begin
                  result_ff <= cpu.lpm_data;
                  st_ff     <= SPMFLR_ST_FINISH;
               end
            end
            SPMFLR_ST_FINISH: begin
               ints_ff <= 1'b0;
               if (op_ff == SPMFLR_OP_LOAD) begin
                  z_ff <= z_ff + SPMFLR_ZW'(2);
               end
               st_ff <= SPMFLR_ST_IDLE;
            end
            default: st_ff <= SPMFLR_ST_IDLE;
         endcase
      end
   end

   assign cpu.ctl_wr    = ctl_wr_ff;
   assign cpu.ctl_wdata = ctl_wdata_ff;
   assign cpu.lpm_req   = lpm_req_ff;
   assign cpu.lpm_addr  = z_ff;
   assign cpu.spm_req   = spm_req_ff;
   assign cpu.spm_addr  = z_ff;
   assign cpu.spm_data  = wdata_ff;
   assign hreadyout     = 1'b1;
   assign hresp         = SPMFLR_HRESP_OK;
   assign hrdata        = hrdata_ff;
   assign ints_blocked  = ints_ff;
endmodule
